// File: rtl/spi_irq_cs_params.svh
// Constants of the serial controller: offsets, field positions, timing counts
`ifndef SPI_IRQ_CS_PARAMS_SVH
`define SPI_IRQ_CS_PARAMS_SVH
`define OFS_CTRL     8'h00
`define OFS_STATUS   8'h04
`define OFS_TXD      8'h08
`define OFS_RXD      8'h0c
`define OFS_IRQ_SET  8'h10
`define OFS_IRQ_CLR  8'h14
`define OFS_IRQ_MASK 8'h18
`define CSR_BLOCK    4'h2
`define BIT_EN       0
`define BIT_DIS      1
`define BIT_LAST     24
`define PCS_LSB      16
`define STAT_EN_BIT  16
`define IRQ_W        10
`define CHAR_BASE    5'd8
`define WORD_BITS    5'd16
`define INTER_MUL    13'd32
`define CS_GAP       13'd6
`define CS_NONE      4'hf
`define IDLE_RST     1'b1
`endif

// File: rtl/spi_irq_cs_pkg.sv
// Types and helper functions of the serial controller
`include "spi_irq_cs_params.svh"
package spi_irq_cs_pkg;
    typedef struct packed {
        logic [7:0] inter_char_delay;
        logic [7:0] pre_clock_delay;
        logic [7:0] baud_divisor;
        logic [3:0] char_bits;
        logic       select_hold_after;
        logic       rsvd;
        logic       capture_edge_select;
        logic       clock_idle_level;
    } csr_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_DESEL = 5'b00010,
        ST_PRE   = 5'b00100,
        ST_SHIFT = 5'b01000,
        ST_GAP   = 5'b10000
    } seq_state_t;

    function automatic logic [4:0] char_len(input logic [3:0] code);
        return 5'(code) + `CHAR_BASE;
    endfunction

    // First half of a serial clock period (idle level), rounded up
    function automatic logic [7:0] half_a(input logic [7:0] div);
        return div - (div >> 1);
    endfunction

    // Second half (active level), never below one cycle
    function automatic logic [7:0] half_b(input logic [7:0] div);
        return (div < 8'h02) ? 8'h01 : (div >> 1);
    endfunction
endpackage

// File: rtl/spi_delay_timer.sv
// Down counter that times the select, pre-clock and inter-character delays
`timescale 1ns/10ps
`default_nettype none
module spi_delay_timer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Load and status
    input  wire logic        load,
    input  wire logic [12:0] value,
    output logic             expired
);
    logic [12:0] count_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_ff <= '0;
        end else if (load) begin
            count_ff <= value;
        end else if (count_ff != '0) begin
            count_ff <= count_ff - 13'h0001;
        end
    end

    assign expired = (count_ff == '0);
endmodule
`default_nettype wire

// File: rtl/spi_char_shifter.sv
// Serializer for one character: clock generation, shift out and sample in
`timescale 1ns/10ps
`default_nettype none
`include "spi_irq_cs_params.svh"
module spi_char_shifter (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    // Character request
    input  wire logic                 start,
    input  wire spi_irq_cs_pkg::csr_t cfg,
    input  wire logic [15:0]          tx_word,
    output logic                      busy,
    output logic                      done,
    output logic [15:0]               rx_word,
    // Serial lines
    input  wire logic                 miso,
    output logic                      sclk,
    output logic                      mosi
);
    spi_irq_cs_pkg::csr_t cfg_ff;
    logic        busy_ff;
    logic        level_ff;
    logic        done_ff;
    logic        sclk_ff;
    logic        mosi_ff;
    logic [7:0]  div_ff;
    logic [5:0]  edges_ff;
    logic [15:0] tx_ff;
    logic [15:0] rx_ff;

    wire logic [4:0]  n_bits   = spi_irq_cs_pkg::char_len(cfg.char_bits);
    wire logic [15:0] aligned  = tx_word << (`WORD_BITS - n_bits);
    wire logic        edge_now = busy_ff & (div_ff == 8'h01);
    wire logic        leading  = ~level_ff;
    wire logic        on_cap   = (leading == cfg_ff.capture_edge_select);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_ff   <= '0;
            busy_ff  <= 1'b0;
            level_ff <= 1'b0;
            done_ff  <= 1'b0;
            sclk_ff  <= 1'b0;
            mosi_ff  <= 1'b0;
            div_ff   <= '0;
            edges_ff <= '0;
            tx_ff    <= '0;
            rx_ff    <= '0;
        end else begin
            done_ff <= 1'b0;
            if (start) begin
                cfg_ff   <= cfg;
                busy_ff  <= 1'b1;
                level_ff <= 1'b0;
                sclk_ff  <= cfg.clock_idle_level;
                div_ff   <= spi_irq_cs_pkg::half_a(cfg.baud_divisor);
                edges_ff <= {n_bits, 1'b0};
                rx_ff    <= '0;
                // Capture on leading edge: first bit must already stand
                mosi_ff  <= cfg.capture_edge_select & aligned[15];
                tx_ff    <= cfg.capture_edge_select ? (aligned << 1) : aligned;
            end else if (edge_now) begin
                level_ff <= ~level_ff;
                sclk_ff  <= ~sclk_ff;
                div_ff   <= leading ? spi_irq_cs_pkg::half_b(cfg_ff.baud_divisor)
                                    : spi_irq_cs_pkg::half_a(cfg_ff.baud_divisor);
                edges_ff <= edges_ff - 6'h01;
                if (edges_ff == 6'h01) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
                if (on_cap) begin
                    rx_ff <= {rx_ff[14:0], miso};
                end else begin
                    mosi_ff <= tx_ff[15];
                    tx_ff   <= tx_ff << 1;
                end
            end else if (busy_ff) begin
                div_ff <= div_ff - 8'h01;
            end
        end
    end

    assign busy    = busy_ff;
    assign done    = done_ff;
    assign rx_word = rx_ff;
    assign sclk    = sclk_ff;
    assign mosi    = mosi_ff;
endmodule
`default_nettype wire

// File: rtl/spi_irq_cs_timing.sv
// Serial controller: register slave, interrupt mask, per-select timing sequencer
//
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "spi_irq_cs_params.svh"
module spi_irq_cs_timing (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Serial lines
    output logic             serial_clock_pin,
    output logic             mosi_pin,
    input  wire logic        miso_pin,
    output logic [3:0]       chip_select_pins_n,
    // Interrupt
    output logic             irq
);
    // ************************************************************
    // Bus decode
    // ************************************************************
    logic       dp_wr_ff;
    logic [7:0] dp_addr_ff;

    wire logic       addr_ok  = hsel & htrans[1] & hready;
    wire logic       rd_go    = addr_ok & ~hwrite;
    wire logic [7:0] rd_addr  = haddr[7:0];
    wire logic       wr_ctrl  = dp_wr_ff & (dp_addr_ff == `OFS_CTRL);
    wire logic       wr_txd   = dp_wr_ff & (dp_addr_ff == `OFS_TXD);
    wire logic       wr_set   = dp_wr_ff & (dp_addr_ff == `OFS_IRQ_SET);
    wire logic       wr_clr   = dp_wr_ff & (dp_addr_ff == `OFS_IRQ_CLR);
    wire logic       wr_csr   = dp_wr_ff & (dp_addr_ff[7:4] == `CSR_BLOCK);
    wire logic [1:0] csr_widx = dp_addr_ff[3:2];
    wire logic       rd_rxd   = rd_go & (rd_addr == `OFS_RXD);
    wire logic       rd_stat  = rd_go & (rd_addr == `OFS_STATUS);
    wire logic       cmd_en   = wr_ctrl & hwdata[`BIT_EN];
    wire logic       cmd_dis  = wr_ctrl & hwdata[`BIT_DIS];

    // ************************************************************
    // Registers and state
    // ************************************************************
    spi_irq_cs_pkg::csr_t       csr_ff [4];
    spi_irq_cs_pkg::seq_state_t state_ff;
    spi_irq_cs_pkg::seq_state_t nxt_state;
    logic              en_ff;
    logic              tx_empty_ff;
    logic              rx_full_ff;
    logic              ovr_ff;
    logic              idle_ff;
    logic              irq_ff;
    logic [`IRQ_W-1:0] mask_ff;
    logic [15:0]       rx_data_ff;
    logic [15:0]       hold_word_ff;
    logic [1:0]        hold_idx_ff;
    logic              hold_last_ff;
    logic              char_last_ff;
    logic [1:0]        cur_idx_ff;
    logic              cs_act_ff;
    logic [31:0]       hrdata_ff;
    logic              shift_go;
    logic              cs_on;
    logic              cs_off;
    logic              dly_load;
    logic [12:0]       dly_val;
    logic              dly_expired;
    logic              sh_busy;
    logic              sh_done;
    logic              sh_sclk;
    logic [15:0]       sh_rx;

    wire spi_irq_cs_pkg::csr_t cur_cfg  = csr_ff[cur_idx_ff];
    wire spi_irq_cs_pkg::csr_t hold_cfg = csr_ff[hold_idx_ff];
    wire logic hold_valid = en_ff & ~tx_empty_ff;
    wire logic same_cs    = cs_act_ff & (cur_idx_ff == hold_idx_ff);
    // Zero pre-clock field means half a serial clock period
    wire logic [12:0] pre_val = (hold_cfg.pre_clock_delay == 8'h00)
        ? 13'(spi_irq_cs_pkg::half_a(hold_cfg.baud_divisor))
        : 13'(hold_cfg.pre_clock_delay);
    wire logic [12:0] gap_val = 13'(cur_cfg.inter_char_delay) * `INTER_MUL;
    // Idle only when no further character waits in the holding register
    wire logic idle_set = (state_ff == spi_irq_cs_pkg::ST_GAP) & dly_expired & ~shift_go
                          & ~hold_valid;
    // Source layout: 9 shifter idle, 8 select rise, 7..4 DMA, 3 overrun, 2 fault
    wire logic [`IRQ_W-1:0] flags = {idle_ff, 1'b0, 4'h0, ovr_ff, 1'b0,
                                     tx_empty_ff, rx_full_ff};
    wire logic [31:0] stat_word = 32'(flags) | (32'(en_ff) << `STAT_EN_BIT);
    wire logic [31:0] rd_mux =
        (rd_addr == `OFS_STATUS)     ? stat_word :
        (rd_addr == `OFS_RXD)        ? 32'(rx_data_ff) :
        (rd_addr == `OFS_IRQ_MASK)   ? 32'(mask_ff) :
        (rd_addr[7:4] == `CSR_BLOCK) ? csr_ff[rd_addr[3:2]] : 32'h0000_0000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dp_wr_ff   <= 1'b0;
            dp_addr_ff <= '0;
            hrdata_ff  <= '0;
        end else begin
            dp_wr_ff   <= addr_ok & hwrite;
            dp_addr_ff <= haddr[7:0];
            hrdata_ff  <= rd_go ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_ff <= '0;
        end else if (wr_set | wr_clr) begin
            mask_ff <= (mask_ff | ({`IRQ_W{wr_set}} & hwdata[`IRQ_W-1:0]))
                     & ~({`IRQ_W{wr_clr}} & hwdata[`IRQ_W-1:0]);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 4; i++) begin
                csr_ff[i] <= '0;
            end
        end else if (wr_csr) begin
            csr_ff[csr_widx] <= hwdata;
        end
    end

    // ************************************************************
    // Enable and flags
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_ff        <= 1'b0;
            tx_empty_ff  <= 1'b0;
            rx_full_ff   <= 1'b0;
            ovr_ff       <= 1'b0;
            idle_ff      <= `IDLE_RST;
            hold_word_ff <= '0;
            hold_idx_ff  <= '0;
            hold_last_ff <= 1'b0;
            rx_data_ff   <= '0;
            irq_ff       <= 1'b0;
        end else begin
            en_ff   <= cmd_dis ? 1'b0 : (cmd_en | en_ff);
            irq_ff  <= |(flags & mask_ff);
            if (cmd_dis) begin
                tx_empty_ff <= 1'b0;
            end else if (shift_go | cmd_en) begin
                tx_empty_ff <= 1'b1;
            end else if (wr_txd & en_ff) begin
                tx_empty_ff <= 1'b0;
            end
            if (wr_txd & en_ff) begin
                hold_word_ff <= hwdata[15:0];
                hold_idx_ff  <= hwdata[`PCS_LSB +: 2];
                hold_last_ff <= hwdata[`BIT_LAST];
            end
            if (idle_set) begin
                idle_ff <= 1'b1;
            end else if (wr_txd & en_ff) begin
                idle_ff <= 1'b0;
            end
            if (sh_done) begin
                rx_data_ff <= sh_rx;
                rx_full_ff <= 1'b1;
            end else if (rd_rxd) begin
                rx_full_ff <= 1'b0;
            end
            if (sh_done & rx_full_ff & ~rd_rxd) begin
                ovr_ff <= 1'b1;
            end else if (rd_stat) begin
                ovr_ff <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Character sequencer
    // ************************************************************
    always_comb begin
        nxt_state = state_ff;
        shift_go  = 1'b0;
        cs_on     = 1'b0;
        cs_off    = 1'b0;
        dly_load  = 1'b0;
        dly_val   = '0;
        unique case (state_ff)
            spi_irq_cs_pkg::ST_IDLE: if (hold_valid) begin
                if (same_cs) begin
                    shift_go  = 1'b1;
                    nxt_state = spi_irq_cs_pkg::ST_SHIFT;
                end else if (cs_act_ff) begin
                    cs_off    = 1'b1;
                    dly_load  = 1'b1;
                    dly_val   = `CS_GAP;
                    nxt_state = spi_irq_cs_pkg::ST_DESEL;
                end else begin
                    cs_on     = 1'b1;
                    dly_load  = 1'b1;
                    dly_val   = pre_val;
                    nxt_state = spi_irq_cs_pkg::ST_PRE;
                end
            end
            spi_irq_cs_pkg::ST_DESEL: if (dly_expired) begin
                cs_on     = hold_valid;
                dly_load  = hold_valid;
                dly_val   = pre_val;
                nxt_state = hold_valid ? spi_irq_cs_pkg::ST_PRE : spi_irq_cs_pkg::ST_IDLE;
            end
            spi_irq_cs_pkg::ST_PRE: if (dly_expired) begin
                shift_go  = hold_valid;
                nxt_state = hold_valid ? spi_irq_cs_pkg::ST_SHIFT : spi_irq_cs_pkg::ST_IDLE;
            end
            spi_irq_cs_pkg::ST_SHIFT: if (sh_done) begin
                dly_load  = 1'b1;
                dly_val   = gap_val;
                nxt_state = spi_irq_cs_pkg::ST_GAP;
            end
            spi_irq_cs_pkg::ST_GAP: if (dly_expired) begin
                if (hold_valid & same_cs & ~char_last_ff) begin
                    shift_go  = 1'b1;
                    nxt_state = spi_irq_cs_pkg::ST_SHIFT;
                end else begin
                    cs_off    = char_last_ff | ~cur_cfg.select_hold_after;
                    nxt_state = spi_irq_cs_pkg::ST_IDLE;
                end
            end
            default: nxt_state = spi_irq_cs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff     <= spi_irq_cs_pkg::ST_IDLE;
            cs_act_ff    <= 1'b0;
            cur_idx_ff   <= '0;
            char_last_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            cs_act_ff <= cs_on | (cs_act_ff & ~cs_off);
            if (cs_on) begin
                cur_idx_ff <= hold_idx_ff;
            end
            if (shift_go) begin
                char_last_ff <= hold_last_ff;
            end
        end
    end

    spi_delay_timer u_delay (
        .clk     (clk),
        .arst_n  (arst_n),
        .load    (dly_load),
        .value   (dly_val),
        .expired (dly_expired)
    );

    spi_char_shifter u_shift (
        .clk     (clk),
        .arst_n  (arst_n),
        .start   (shift_go),
        .cfg     (cur_cfg),
        .tx_word (hold_word_ff),
        .busy    (sh_busy),
        .done    (sh_done),
        .rx_word (sh_rx),
        .miso    (miso_pin),
        .sclk    (sh_sclk),
        .mosi    (mosi_pin)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign serial_clock_pin   = sh_busy ? sh_sclk : cur_cfg.clock_idle_level;
    assign chip_select_pins_n = cs_act_ff ? ~(4'h1 << cur_idx_ff) : `CS_NONE;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign hrdata             = hrdata_ff;
    assign irq                = irq_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    logic [12:0] wait_cnt_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt_ff <= '0;
        end else begin
            wait_cnt_ff <= (state_ff == nxt_state) ? wait_cnt_ff + 13'h0001 : '0;
        end
    end

    a_irq_set_bits: assert property (@(posedge clk) disable iff (!arst_n)
        wr_set & ~wr_clr |=> ((mask_ff & $past(hwdata[9:0])) == $past(hwdata[9:0])))
        else $error("enable-set write did not enable its sources");
    a_irq_set_keep: assert property (@(posedge clk) disable iff (!arst_n)
        wr_set & ~wr_clr |=> ((mask_ff & $past(mask_ff)) == $past(mask_ff)))
        else $error("enable-set write dropped an enabled source");
    a_irq_clr_bits: assert property (@(posedge clk) disable iff (!arst_n)
        wr_clr |=> ((mask_ff & $past(hwdata[9:0])) == 10'h000))
        else $error("enable-clear write left a source enabled");
    a_mask_readback: assert property (@(posedge clk) disable iff (!arst_n)
        rd_go & (rd_addr == `OFS_IRQ_MASK) & ~dp_wr_ff |=> hrdata == 32'($past(mask_ff)))
        else $error("mask view differs from enable state");
    a_en_status_bit: assert property (@(posedge clk) disable iff (!arst_n)
        rd_stat & ~dp_wr_ff |=> hrdata[`STAT_EN_BIT] == $past(en_ff))
        else $error("enable status bit wrong");
    a_clk_idle_lvl: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == spi_irq_cs_pkg::ST_PRE) |-> serial_clock_pin == cur_cfg.clock_idle_level)
        else $error("serial clock not at idle level before first edge");
    a_pre_delay_len: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == spi_irq_cs_pkg::ST_PRE) & dly_expired & ~$past(wr_csr)
        |-> wait_cnt_ff == 13'(pre_val))
        else $error("pre-clock delay length wrong");
    a_gap_delay_len: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == spi_irq_cs_pkg::ST_GAP) & dly_expired & ~$past(wr_csr)
        |-> wait_cnt_ff == gap_val)
        else $error("inter-character delay length wrong");
    a_cs_release: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == spi_irq_cs_pkg::ST_GAP) & dly_expired & ~shift_go
        & ~cur_cfg.select_hold_after |=> chip_select_pins_n == `CS_NONE)
        else $error("select not released after last character");
    a_idle_clear: assert property (@(posedge clk) disable iff (!arst_n)
        wr_txd & en_ff & ~idle_set |=> ~idle_ff ##1 ~idle_ff)
        else $error("shifter idle flag not cleared by data write");
    a_txe_disabled: assert property (@(posedge clk) disable iff (!arst_n)
        ~en_ff |-> ~tx_empty_ff)
        else $error("transmit empty set while disabled");
    a_irq_follow: assert property (@(posedge clk) disable iff (!arst_n)
        |(flags & mask_ff) |=> irq)
        else $error("interrupt not raised for enabled flag");

    c_char_done: cover property (@(posedge clk) disable iff (!arst_n) sh_done);
    c_back2back: cover property (@(posedge clk) disable iff (!arst_n)
        (state_ff == spi_irq_cs_pkg::ST_GAP) & shift_go);
    c_cs_switch: cover property (@(posedge clk) disable iff (!arst_n)
        state_ff == spi_irq_cs_pkg::ST_DESEL);
endmodule
`default_nettype wire

// File: testbench/spi_peer.sv
// Serial peripheral model on select 0
`timescale 1ns/10ps
`default_nettype none
module spi_peer (
    // Serial lines
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        mosi,
    output logic             miso,
    // Captured word
    output logic [15:0]      got
);
    initial begin
        got  = 16'h0000;
        miso = 1'b0;
    end
    always @(negedge cs_n) got <= 16'h0000;
    // Idle high, phase 0: capture on the rising trailing edge
    always @(posedge sclk) if (!cs_n) got <= {got[14:0], mosi};
    always @(negedge sclk) if (!cs_n) miso <= got[0];
    // Released line shows the inverse of its last level
    always @(posedge cs_n) miso <= ~miso;
endmodule
`default_nettype wire

// File: testbench/spi_irq_and_cs_timing_test.sv
// Bench for the serial controller registers and select timing
`timescale 1ns/10ps
`default_nettype none
module spi_irq_and_cs_timing_test;
logic        clk, arst_n, hsel, hwrite, hrdy, miso, sclk, mosi, irq;
logic [31:0] haddr, hwdata, hrdata, q, s, c, e, p;
logic [1:0]  htrans;
logic [3:0]  cs_n;
logic [15:0] got;
logic [9:0]  m;
int          seed, n, error_cnt, total_checks;
spi_irq_cs_timing dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hresp(), .hrdata(hrdata), .serial_clock_pin(sclk),
    .mosi_pin(mosi), .miso_pin(miso), .chip_select_pins_n(cs_n), .irq(irq));
spi_peer peer (.sclk(sclk), .cs_n(cs_n[0]), .mosi(mosi), .miso(miso), .got(got));
task close_out;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
task chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
        error_cnt++;
        $display("[FAIL] %0t got %h want %h", $time, g, x);
    end
endtask
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do begin @(posedge clk); k++; end while (hrdy !== 1'b1 && k < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do begin @(posedge clk); k++; end while (hrdy !== 1'b1 && k < 50);
    q = hrdata;
    if (k >= 50) begin error_cnt++; close_out(); end
endtask
initial begin clk = 1'b0; forever #20 clk = ~clk; end
initial begin
    seed = 78216; error_cnt = 0; total_checks = 0; m = 10'h000;
    arst_n = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0;
    haddr = 32'h0; hwdata = 32'h0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(0, 8'h04, 0); chk(q, 32'h0000_0200);
    bus(1, 8'h10, 32'hffff_ffff); bus(0, 8'h18, 0); chk(q, 32'h3ff);
    m = 10'h3ff;
    for (int i = 0; i < 6; i++) begin
        s = $random(seed); c = $random(seed);
        bus(1, 8'h10, s); bus(1, 8'h14, c);
        m = (m | s[9:0]) & ~c[9:0];
        bus(0, 8'h18, 0); chk(q, {22'h0, m});
    end
    $display("mask test done");
    for (int i = 1; i < 4; i++) begin
        s = $random(seed);
        bus(1, 8'h20 + 8'(4 * i), s); bus(0, 8'h20 + 8'(4 * i), 0); chk(q, s);
    end
    $display("config test done");
    bus(1, 8'h20, 32'h0000_0401);
    @(negedge clk); chk(sclk, 1);
    bus(1, 8'h00, 1); bus(0, 8'h04, 0); chk(q, 32'h0001_0202);
    bus(1, 8'h14, 32'h3ff); bus(1, 8'h10, 32'h200);
    // Interrupt flop follows the mask one cycle after the write lands
    repeat (2) @(negedge clk);
    chk(irq, 1);
    bus(1, 8'h08, 32'h0100_00a5);
    n = 0;
    while (cs_n === 4'hf && n < 100) begin @(negedge clk); n++; end
    chk({28'h0, cs_n}, 32'he); chk(irq, 0);
    e = 0; p = sclk;
    while (cs_n !== 4'hf && n < 400) begin
        @(negedge clk); n++;
        if (sclk !== p) e++;
        p = sclk;
    end
    chk(e, 16);
    chk({16'h0, got}, 32'ha5);
    @(posedge clk); bus(0, 8'h04, 0); chk(q, 32'h0001_0203);
    chk(n < 400, 1);
    chk(irq, 1);
    // Peer echoes what it has shifted in, one bit behind
    bus(0, 8'h0c, 0); chk(q, 32'h0000_0052);
    $display("transfer test done");
    // Second frame: idle low, capture on leading edge, 16 bits, select held
    s = $random(seed);
    bus(1, 8'h20, 32'h0000_028a);
    @(negedge clk); chk(sclk, 0);
    bus(1, 8'h08, {16'h0, s[15:0]});
    e = 0; n = 0; p = sclk;
    while (e < 32 && n < 400) begin
        @(negedge clk); n++;
        if (sclk !== p) e++;
        p = sclk;
    end
    repeat (4) @(negedge clk);
    chk(e, 32);
    chk({16'h0, got}, {16'h0, s[15:0]});
    chk({28'h0, cs_n}, 32'he);
    chk(sclk, 0);
    @(posedge clk); bus(0, 8'h04, 0); chk(q, 32'h0001_0203);
    $display("held select test done");
    close_out();
end
endmodule
`default_nettype wire
